// file: verilog/nic_pkg.sv
`default_nettype none
package nic_pkg;
	// level bit pairs {high, low}
	localparam logic [1:0] LVL0 = 2'b10;
	localparam logic [1:0] LVL1 = 2'b01;
	localparam logic [1:0] LVL2 = 2'b00;
	localparam logic [1:0] LVL3 = 2'b11;
	// condition-code bit positions of the level
	localparam int CC_BIT_HIGH = 5;
	localparam int CC_BIT_LOW  = 3;
	// vector table, top of memory
	localparam logic [15:0] VEC_RESET = 16'hfffe;
	localparam logic [15:0] VEC_TRAP  = 16'hfffc;
	localparam logic [15:0] VEC_MASK0 = 16'hfffa;
	localparam logic [15:0] VEC_BASE  = 16'hffe0;
	// source counts
	localparam int NVEC = 14;
	localparam int NEXT = 4;
	localparam int NPER = 10;
	localparam int NPIN = 8;
	// register byte offsets
	localparam logic [7:0] OFS_PRIO0 = 8'h00;
	localparam logic [7:0] OFS_PRIO1 = 8'h04;
	localparam logic [7:0] OFS_PRIO2 = 8'h08;
	localparam logic [7:0] OFS_PRIO3 = 8'h0c;
	localparam logic [7:0] OFS_SENS  = 8'h10;
	localparam logic [7:0] OFS_PSEL  = 8'h14;
	localparam logic [7:0] OFS_PEND  = 8'h18;
	localparam logic [7:0] OFS_STAT  = 8'h1c;
	// reset values
	localparam logic [7:0] PRIO_RST = 8'hff;
	localparam logic [7:0] SENS_RST = 8'h00;
	localparam logic [7:0] PSEL_RST = 8'h00;
	localparam logic [3:0] PRIO3_RO = 4'hf;
	// sensitivity codes per external line
	localparam logic [1:0] SENS_FALL_LOW = 2'b00;
	localparam logic [1:0] SENS_RISE     = 2'b01;
	localparam logic [1:0] SENS_FALL     = 2'b10;
	localparam logic [1:0] SENS_BOTH     = 2'b11;
	// core sequencer to controller
	typedef struct packed {
		logic       boundary;   // instruction completes
		logic       trap_exec;  // trap instruction ran
		logic       stack_done; // context pushed
		logic       cc_wr;      // software level write
		logic [1:0] cc_bits;
		logic       ret;        // handler return, level popped
		logic [1:0] ret_bits;
		logic       halted;
		logic       waiting;
	} nic_cpu_in_t;
	// controller to core sequencer
	typedef struct packed {
		logic        stack_req;
		logic        vec_load;
		logic [15:0] vector;
	} nic_svc_t;
	typedef enum logic [3:0] {
		ST_RSTV  = 4'b0001,
		ST_IDLE  = 4'b0010,
		ST_STACK = 4'b0100,
		ST_VEC   = 4'b1000
	} nic_state_t;
endpackage : nic_pkg
`default_nettype wire

// file: verilog/nic_ctrl.sv
// Implementation choices: the AHB-Lite register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
// What this block does
// R1 - service starts only at instruction boundary
// R2 - request context push before maskable/trap entry
// R3 - maskable entry loads vector's stored level
// R4 - after push, present vector to fetch
// R5 - vector table from ffe0 to ffff
// R6 - handler return restores popped level bits
// R7 - level in cc bits five and three
// R8 - level codes 10,01,00,11 low to high
// R9 - four levels, sixteen fixed vectors
// R10 - highest level wins, then hardware priority
// R11 - unique hardware priority gives one winner
// R12 - unserved requests stay latched pending; a sensitivity or pin-select change drops that line's edge latch
// R13 - reset and trap outrank all maskables
// R14 - nmi ignores level, sets level three
// R15 - reset and trap wake from halt
// R16 - trap instruction raises trap service
// R17 - reset runs at level three first
// R18 - serve only enabled, higher than current
// R19 - pins wake halt, sensitivity selectable
// R20 - edge latch cleared at service entry
// R21 - selected pins of a line ored
// R22 - peripheral request needs flag and enable
// R23 - source zero highest hardware priority
// R24 - level-zero field writes are ignored
// R25 - any enabled request wakes from wait
// R26 - arbitrate afresh at every boundary
module nic_ctrl (
	input  wire logic                     hclk,
	input  wire logic                     hresetn,
	input  wire logic                     hsel,
	input  wire logic [31:0]              haddr,
	input  wire logic [1:0]               htrans,
	input  wire logic                     hwrite,
	input  wire logic [2:0]               hsize,
	input  wire logic [31:0]              hwdata,
	input  wire logic                     hready,
	output logic                          hreadyout,
	output logic                          hresp,
	output logic [31:0]                   hrdata,
	input  wire nic_pkg::nic_cpu_in_t     cpu_in,
	output nic_pkg::nic_svc_t             svc,
	output logic [7:0]                    cc_level,
	output logic                          wake,
	input  wire logic [nic_pkg::NPIN-1:0] ext_pin,
	input  wire logic [nic_pkg::NPER-1:0] per_flag,
	input  wire logic [nic_pkg::NPER-1:0] per_en,
	input  wire logic [nic_pkg::NPER-1:0] per_clr
);
	// level code to rank 0..3
	function automatic logic [1:0] rank(input logic [1:0] b);
		case (b)
			nic_pkg::LVL0: rank = 2'd0;
			nic_pkg::LVL1: rank = 2'd1;
			nic_pkg::LVL2: rank = 2'd2;
			default:       rank = 2'd3;
		endcase
	endfunction : rank

	// field-wise write, level-zero code keeps the old field
	function automatic logic [7:0] wr_prio(input logic [7:0] o,
		input logic [7:0] n);
		logic [7:0] r;
		r = o;
		for (int k = 0; k < 4; k++) begin
			if (n[2*k+:2] != nic_pkg::LVL0) begin
				r[2*k+:2] = n[2*k+:2]; // R24
			end
		end
		return r;
	endfunction : wr_prio

	// winner {found, index}; lower index wins a tie
	function automatic logic [4:0] arb(input logic [13:0] el,
		input logic [31:0] pri);
		logic       f;
		logic [1:0] best;
		logic [3:0] idx;
		f = 1'b0;
		best = 2'd0;
		idx = 4'd0;
		for (int i = 13; i >= 0; i--) begin
			if (el[i] && (!f || rank(pri[2*i+:2]) >= best)) begin // R10 R23
				f = 1'b1;
				best = rank(pri[2*i+:2]);
				idx = 4'(i);
			end
		end
		return {f, idx};
	endfunction : arb

	// bus pipeline
	logic              dwr_q;      // write data phase pending
	logic              drd_q;
	logic [7:0]        daddr_q;    // latched byte offset
	logic              hit_q;      // address inside window
	logic [7:0]        prio_q [4]; // per-vector levels
	logic [7:0]        prio_d [4];
	logic [7:0]        sens_q, sens_d;
	logic [7:0]        psel_q, psel_d;
	// source latches
	logic [3:0]        line_prev_q; // last level of each line
	logic [3:0]        edge_q, edge_d;
	logic [9:0]        per_q;
	logic              trap_q;
	// service sequencer
	nic_pkg::nic_state_t st_q;
	logic              srv_nmi_q;  // trap being served
	logic [3:0]        srv_idx_q;

	// address phase qualifier
	wire        aph  = hsel & htrans[1] & hready;
	wire        amap = (haddr[31:5] == 27'h0) && (haddr[1:0] == 2'b00);
	wire [7:0]  wd   = hwdata[7:0];

	// register next values, writes land in the data phase
	always_comb begin
		for (int r = 0; r < 4; r++) begin
			prio_d[r] = prio_q[r];
			if (dwr_q && hit_q && daddr_q[7:2] == 6'(r)) begin
				prio_d[r] = wr_prio(prio_q[r], wd);
			end
		end
		prio_d[3][7:4] = nic_pkg::PRIO3_RO; // fixed upper fields
		sens_d = sens_q;
		psel_d = psel_q;
		if (dwr_q && hit_q && daddr_q == nic_pkg::OFS_SENS) begin
			sens_d = wd;
		end
		if (dwr_q && hit_q && daddr_q == nic_pkg::OFS_PSEL) begin
			psel_d = wd;
		end
	end

	// flat field view, vector i at bits 2i+1:2i
	wire [31:0] pri = {prio_q[3], prio_q[2], prio_q[1], prio_q[0]};

	// pins grouped two to a line, selected pins ored
	wire [3:0] line_lvl; // R21
	wire [3:0] line_en;
	wire [3:0] line_rise = line_lvl & ~line_prev_q;
	wire [3:0] line_fall = ~line_lvl & line_prev_q;
	wire [3:0] line_evt;
	wire [3:0] line_lowreq;
	genvar g;
	for (g = 0; g < 4; g++) begin : g_line
		wire [1:0] s = sens_q[2*g+:2];
		assign line_lvl[g] = |(ext_pin[2*g+:2] & psel_q[2*g+:2]);
		assign line_en[g]  = |psel_q[2*g+:2];
		assign line_evt[g] =
			(s == nic_pkg::SENS_RISE) ? line_rise[g] :
			(s == nic_pkg::SENS_BOTH) ? (line_rise[g] | line_fall[g]) :
			line_fall[g]; // R19
		assign line_lowreq[g] = (s == nic_pkg::SENS_FALL_LOW) &
			~line_lvl[g] & line_en[g];
	end

	// pending and enabled sets
	wire [13:0] pend = {per_q, edge_q | line_lowreq};
	wire [13:0] enab = {per_en, line_en};
	wire [13:0] elig = pend & enab; // R18
	wire [4:0]  win  = arb(elig, pri); // R11
	wire [1:0]  win_lvl = pri[2*win[3:0]+:2];
	wire [1:0]  cur  = cc_level[nic_pkg::CC_BIT_HIGH -: 1] == 1'b0 ?
		{1'b0, cc_level[nic_pkg::CC_BIT_LOW]} :
		{1'b1, cc_level[nic_pkg::CC_BIT_LOW]};
	wire        take_mask = win[4] && rank(win_lvl) > rank(cur); // R18
	wire        take = cpu_in.boundary && st_q == nic_pkg::ST_IDLE &&
		(trap_q || take_mask); // R1 R26

	// a sensitivity change drops that line's latch
	wire [3:0]  sens_chg;
	for (g = 0; g < 4; g++) begin : g_chg
		assign sens_chg[g] = sens_d[2*g+:2] != sens_q[2*g+:2] ||
			psel_d[2*g+:2] != psel_q[2*g+:2];
	end
	wire entering = st_q == nic_pkg::ST_STACK && cpu_in.stack_done;
	wire [3:0] ent_clr = (entering && !srv_nmi_q && srv_idx_q < 4'd4) ?
		4'(1 << srv_idx_q[1:0]) : 4'd0;
	// new edge wins over entry clear
	assign edge_d = (edge_q & ~ent_clr & ~sens_chg) | (line_evt & line_en); // R20 R12

	// read mux uses next values so write-then-read sees new data
	wire [7:0] stat = {2'b00, st_q == nic_pkg::ST_IDLE, trap_q,
		2'b00, cur};
	wire [31:0] rd_mux =
		(haddr[7:0] == nic_pkg::OFS_PRIO0) ? {24'h0, prio_d[0]} :
		(haddr[7:0] == nic_pkg::OFS_PRIO1) ? {24'h0, prio_d[1]} :
		(haddr[7:0] == nic_pkg::OFS_PRIO2) ? {24'h0, prio_d[2]} :
		(haddr[7:0] == nic_pkg::OFS_PRIO3) ? {24'h0, prio_d[3]} :
		(haddr[7:0] == nic_pkg::OFS_SENS)  ? {24'h0, sens_d} :
		(haddr[7:0] == nic_pkg::OFS_PSEL)  ? {24'h0, psel_d} :
		(haddr[7:0] == nic_pkg::OFS_PEND)  ? {17'h0, trap_q, pend} :
		(haddr[7:0] == nic_pkg::OFS_STAT)  ? {24'h0, stat} :
		32'h0;

	// bus slave: zero wait, always okay, unmapped reads zero
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dwr_q     <= 1'b0;
			drd_q     <= 1'b0;
			daddr_q   <= 8'h00;
			hit_q     <= 1'b0;
			hrdata    <= 32'h0;
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end else begin
			dwr_q     <= aph & hwrite;
			drd_q     <= aph & ~hwrite;
			daddr_q   <= haddr[7:0];
			hit_q     <= amap;
			hrdata    <= (aph && !hwrite && amap) ? rd_mux : 32'h0;
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end
	end

	// configuration registers
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			for (int r = 0; r < 4; r++) begin
				prio_q[r] <= nic_pkg::PRIO_RST;
			end
			sens_q <= nic_pkg::SENS_RST;
			psel_q <= nic_pkg::PSEL_RST;
		end else begin
			for (int r = 0; r < 4; r++) begin
				prio_q[r] <= prio_d[r];
			end
			sens_q <= sens_d;
			psel_q <= psel_d;
		end
	end

	// request latches
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			line_prev_q <= 4'h0;
			edge_q      <= 4'h0;
			per_q       <= 10'h0;
			trap_q      <= 1'b0;
		end else begin
			line_prev_q <= line_lvl;
			edge_q      <= edge_d;
			// clear sequence discards, as the peripheral expects
			per_q <= (per_q | (per_flag & per_en)) & ~per_clr; // R22
			// trap set wins over its entry clear
			trap_q <= (trap_q & ~(entering & srv_nmi_q)) |
				cpu_in.trap_exec; // R16
		end
	end

	// service sequencer
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st_q      <= nic_pkg::ST_RSTV;
			srv_nmi_q <= 1'b0;
			srv_idx_q <= 4'd0;
			svc       <= '{stack_req: 1'b0, vec_load: 1'b0,
				vector: nic_pkg::VEC_RESET};
			cc_level  <= 8'h28; // level three after reset
		end else begin
			svc.vec_load <= 1'b0;
			case (st_q)
				// reset vector, no stacking
				nic_pkg::ST_RSTV: begin
					svc.vector   <= nic_pkg::VEC_RESET; // R5 R17
					svc.vec_load <= 1'b1;
					st_q         <= nic_pkg::ST_IDLE;
				end
				nic_pkg::ST_IDLE: begin
					if (take) begin
						svc.stack_req <= 1'b1; // R2
						srv_nmi_q     <= trap_q; // R13
						srv_idx_q     <= win[3:0];
						st_q          <= nic_pkg::ST_STACK;
					end
				end
				// wait for the core to push context
				nic_pkg::ST_STACK: begin
					if (cpu_in.stack_done) begin
						svc.stack_req <= 1'b0;
						svc.vec_load  <= 1'b1; // R4
						svc.vector    <= srv_nmi_q ? nic_pkg::VEC_TRAP :
							16'(nic_pkg::VEC_MASK0 - {srv_idx_q, 1'b0}); // R9
						st_q          <= nic_pkg::ST_VEC;
					end
				end
				nic_pkg::ST_VEC: begin
					st_q <= nic_pkg::ST_IDLE;
				end
				default: begin
					st_q <= nic_pkg::ST_IDLE;
				end
			endcase
			// level bits: entry, then return, then software write
			if (entering) begin
				{cc_level[nic_pkg::CC_BIT_HIGH],
					cc_level[nic_pkg::CC_BIT_LOW]} <= srv_nmi_q ?
					nic_pkg::LVL3 : pri[2*srv_idx_q+:2]; // R3 R14 R7 R8
			end else if (cpu_in.ret) begin
				{cc_level[nic_pkg::CC_BIT_HIGH],
					cc_level[nic_pkg::CC_BIT_LOW]} <= cpu_in.ret_bits; // R6
			end else if (cpu_in.cc_wr) begin
				{cc_level[nic_pkg::CC_BIT_HIGH],
					cc_level[nic_pkg::CC_BIT_LOW]} <= cpu_in.cc_bits;
			end
		end
	end

	// wake: halt by pins or trap, wait by anything enabled
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wake <= 1'b0;
		end else begin
			wake <= (cpu_in.halted && (|(elig[3:0]) || trap_q)) || // R15 R19
				(cpu_in.waiting && (|elig || trap_q)); // R25
		end
	end

	// checks
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	a_entry_level: assert property (entering && !srv_nmi_q |=> // R3
		cc_level[5] == $past(pri[2*srv_idx_q+1]) &&
		cc_level[3] == $past(pri[2*srv_idx_q]))
		else $error("entry level not taken from vector field");
	a_nmi_level: assert property (entering && srv_nmi_q |=> // R14
		cc_level[5] && cc_level[3])
		else $error("trap entry did not set level three");
	a_on_boundary: assert property ($rose(svc.stack_req) |-> // R1
		$past(cpu_in.boundary))
		else $error("service began off a boundary");
	a_ret_restore: assert property (cpu_in.ret && !entering |=> // R6
		{cc_level[5], cc_level[3]} == $past(cpu_in.ret_bits))
		else $error("return did not restore level");
	a_mask_gate: assert property ($rose(svc.stack_req) && !srv_nmi_q |-> // R18
		rank(pri[2*srv_idx_q+:2]) > rank($past(cur)))
		else $error("maskable served at or below level");
	a_trap_first: assert property (take && trap_q |=> srv_nmi_q) // R13
		else $error("trap lost arbitration");
	a_vec_follow: assert property (entering |=> svc.vec_load ##1 // R4
		!svc.vec_load)
		else $error("vector load not a single pulse after push");
	a_prio_keep: assert property (dwr_q && hit_q && // R24
		daddr_q == nic_pkg::OFS_PRIO0 && wd[1:0] == nic_pkg::LVL0 |=>
		prio_q[0][1:0] == $past(prio_q[0][1:0]))
		else $error("level zero code was stored");
	a_trap_wake: assert property (cpu_in.halted && trap_q |=> wake) // R15
		else $error("trap failed to wake halt");

	// bus side: slave never stalls and never errors
	a_bus_okay: assert property (hreadyout && !hresp)
		else $error("bus slave stalled or flagged an error");

	// wake must have a reason: halted or waiting one cycle before
	a_wake_cause: assert property (wake |->
		$past(cpu_in.halted) || $past(cpu_in.waiting))
		else $error("wake raised while the core was running");

	// an entry on line zero drops its edge latch unless a new edge
	a_edge_clear: assert property (entering && !srv_nmi_q && // R20
		srv_idx_q == 4'd0 && !line_evt[0] |=> !edge_q[0])
		else $error("edge latch survived service entry");

	// clear sequence discards a pending peripheral request
	a_per_clear: assert property (per_clr[0] |=> !per_q[0]) // R22
		else $error("peripheral latch survived its clear");

	// main scenarios seen at least once
	c_wake: cover property (wake);
	c_mask: cover property (entering && !srv_nmi_q);
	c_trap: cover property (entering && srv_nmi_q);
	c_nest: cover property (entering ##[1:50] entering);
endmodule : nic_ctrl
`default_nettype wire

// file: sim/nic_core_model.sv
`timescale 1ns/1ps
`default_nettype none
// core sequencer stand-in: retires instructions, pushes context on demand
module nic_core_model (
	input  wire logic              hclk,
	input  wire logic              hresetn,
	input  wire logic              run,        // let instructions retire
	input  wire logic              slow,       // shorten the context push
	input  wire nic_pkg::nic_svc_t svc,
	output logic                   boundary,
	output logic                   stack_done
);
	logic [2:0] cyc_q;  // cycles into instruction or push
	logic       done_q; // push already answered, wait for drop
	// boundary every eight cycles; none while pushing, like a real core
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cyc_q <= 3'h0;
			done_q <= 1'b0;
			boundary <= 1'b0;
			stack_done <= 1'b0;
		end else if (svc.stack_req && !done_q) begin
			// cyc_q enters at five: push takes five cycles, or two when slow
			boundary <= 1'b0;
			cyc_q <= cyc_q + 3'h1;
			if (cyc_q == (slow ? 3'h6 : 3'h1)) begin
				stack_done <= 1'b1;
				done_q <= 1'b1;
				cyc_q <= 3'h0;
			end
		end else begin
			// one-cycle done pulse, then normal retiring
			stack_done <= 1'b0;
			if (!svc.stack_req)
				done_q <= 1'b0;
			cyc_q <= cyc_q + 3'h1;
			boundary <= run && cyc_q == 3'h3 && !svc.stack_req;
		end
	end
endmodule : nic_core_model
`default_nettype wire

// file: sim/nic_ctrl_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module nic_ctrl_tb_top;
	logic                 hclk = 1'b0;    // 25 MHz
	logic                 hresetn = 1'b0; // async, low active
	logic                 hsel = 1'b0;
	logic [31:0]          haddr = 32'h0;
	logic [1:0]           htrans = 2'h0;
	logic                 hwrite = 1'b0;
	logic [31:0]          hwdata = 32'h0;
	logic                 hreadyout;
	logic                 hresp;          // always okay, checked after each transfer
	logic [31:0]          hrdata;
	nic_pkg::nic_svc_t    svc;
	logic [7:0]           cc_level;
	logic                 wake;
	logic [7:0]           ext_pin = 8'h0;
	logic [9:0]           per_flag = 10'h0;
	logic [9:0]           per_en = 10'h0;
	logic [9:0]           per_clr = 10'h0;
	logic                 trap = 1'b0;    // trap instruction ran
	logic                 ccw = 1'b0;     // software level write
	logic                 ret = 1'b0;     // handler return
	logic                 hlt = 1'b0;     // core halted
	logic                 wt = 1'b0;      // core waiting
	logic                 run = 1'b0;     // core retires instructions
	logic                 slow = 1'b0;    // shorter context push
	logic [1:0]           ccb = 2'h0;
	logic [1:0]           retb = 2'h0;
	logic                 bnd;
	logic                 sdone;
	nic_pkg::nic_cpu_in_t cpu_in;
	int                   mismatches = 0;
	int                   check_count = 0;
	assign cpu_in = '{bnd, trap, sdone, ccw, ccb, ret, retb, hlt, wt};
	always #20 hclk = ~hclk;
	nic_ctrl nic_ctrl_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
		.hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
		.hresp(hresp), .hrdata(hrdata), .cpu_in(cpu_in), .svc(svc),
		.cc_level(cc_level), .wake(wake), .ext_pin(ext_pin),
		.per_flag(per_flag), .per_en(per_en), .per_clr(per_clr));
	nic_core_model nic_core_model_inst (.hclk(hclk), .hresetn(hresetn),
		.run(run), .slow(slow), .svc(svc), .boundary(bnd),
		.stack_done(sdone));
	// verdict, also reached by an exhausted bus or service wait
	task end_sim;
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : end_sim
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			mismatches++;
			$display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
		end
	endtask : chk
	// one single transfer; waits on hready in both phases
	task bus(input logic w, input logic [7:0] a, input logic [31:0] wd,
		output logic [31:0] rd);
		int   n;
		logic rdy;
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {24'h0, a};
		for (int p = 0; p < 2; p++) begin
			n = 0;
			// sample what stands just before the edge
			do begin
				@(negedge hclk);
				rdy = hreadyout;
				rd = hrdata;
				@(posedge hclk);
				n++;
			end while (rdy !== 1'b1 && n < 50);
			if (n >= 50) begin
				chk(32'h0, 32'h1);
				end_sim();
			end
			if (p == 0) begin
				htrans <= 2'h0;
				hsel <= 1'b0;
				hwdata <= wd;
			end
		end
		chk({31'h0, hresp}, 32'h0);
	endtask : bus
	task rdc(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] d;
		bus(1'b0, a, 32'h0, d);
		chk(d, exp);
	endtask : rdc
	task wr(input logic [7:0] a, input logic [7:0] d);
		logic [31:0] x;
		bus(1'b1, a, {24'h0, d}, x);
	endtask : wr
	// level write or handler return, one-cycle pulse
	task core_op(input logic is_ret, input logic [1:0] b);
		@(posedge hclk);
		ret <= is_ret;
		retb <= b;
		ccw <= !is_ret;
		ccb <= b;
		@(posedge hclk);
		ret <= 1'b0;
		ccw <= 1'b0;
	endtask : core_op
	// next entry: vector, level and whether context was pushed
	task wait_svc(input logic [15:0] v, input logic [7:0] cc, input logic stk);
		int   n;
		logic seen;
		n = 0;
		seen = 1'b0;
		do begin
			@(negedge hclk);
			if (svc.stack_req === 1'b1)
				seen = 1'b1;
			n++;
		end while (svc.vec_load !== 1'b1 && n < 200);
		if (n >= 200) begin
			chk(32'h0, 32'h1);
			end_sim();
		end
		chk(svc.vector, v);
		chk(cc_level, cc);
		chk(seen, stk);
		@(posedge hclk);
	endtask : wait_svc
	task chk_wake;
		int n;
		for (n = 0; n < 20 && wake !== 1'b1; n++)
			@(negedge hclk);
		chk(wake, 1'b1);
		@(posedge hclk);
		hlt <= 1'b0;
	endtask : chk_wake
	task t_reset;
		wait_svc(nic_pkg::VEC_RESET, 8'h28, 1'b0);
		$display("reset entry done");
	endtask : t_reset
	task t_regs;
		rdc(nic_pkg::OFS_PRIO0, 32'hff);
		wr(nic_pkg::OFS_PRIO0, 8'hcf);
		rdc(nic_pkg::OFS_PRIO0, 32'hcf);
		wr(nic_pkg::OFS_PRIO0, 8'h64);
		rdc(nic_pkg::OFS_PRIO0, 32'h44);
		wr(nic_pkg::OFS_PRIO3, 8'h00);
		rdc(nic_pkg::OFS_PRIO3, 32'hf0);
		rdc(8'h20, 32'h0);
		$display("priority registers done");
	endtask : t_regs
	// tie at level two, the tie loser waits, then served after return
	task t_arb;
		wr(nic_pkg::OFS_PRIO1, 8'hd0);
		core_op(1'b0, nic_pkg::LVL0);
		per_en <= 10'h3ff;
		per_flag <= 10'h007;
		run <= 1'b1;
		wait_svc(16'hfff2, 8'h00, 1'b1);
		repeat (40) @(negedge hclk);
		chk(svc.stack_req, 1'b0);
		@(posedge hclk);
		wt <= 1'b1;
		chk_wake();
		wt <= 1'b0;
		per_flag[0] <= 1'b0;
		per_clr[0] <= 1'b1;
		slow <= 1'b1;
		core_op(1'b1, nic_pkg::LVL0);
		per_clr[0] <= 1'b0;
		@(negedge hclk);
		chk(cc_level, 8'h20);
		wait_svc(16'hfff0, 8'h00, 1'b1);
		run <= 1'b0;
		slow <= 1'b0;
		per_flag <= 10'h0;
		per_clr <= 10'h3ff;
		$display("arbitration done");
	endtask : t_arb
	// trap beats a pending maskable, then the maskable follows
	task t_trap;
		@(posedge hclk);
		per_clr <= 10'h0;
		core_op(1'b0, nic_pkg::LVL0);
		per_flag[1] <= 1'b1;
		hlt <= 1'b1;
		trap <= 1'b1;
		@(posedge hclk);
		trap <= 1'b0;
		chk_wake();
		run <= 1'b1;
		wait_svc(nic_pkg::VEC_TRAP, 8'h28, 1'b1);
		core_op(1'b1, nic_pkg::LVL0);
		wait_svc(16'hfff0, 8'h00, 1'b1);
		run <= 1'b0;
		per_flag <= 10'h0;
		per_clr <= 10'h3ff;
		$display("trap done");
	endtask : t_trap
	// rising edge on the second pin of line zero, latched then cleared
	task t_edge;
		@(posedge hclk);
		per_clr <= 10'h0;
		wr(nic_pkg::OFS_SENS, 8'h01);
		wr(nic_pkg::OFS_PSEL, 8'h03);
		@(posedge hclk);
		ext_pin <= 8'h02;
		@(posedge hclk);
		ext_pin <= 8'h00;
		rdc(nic_pkg::OFS_PEND, 32'h1);
		hlt <= 1'b1;
		chk_wake();
		core_op(1'b0, nic_pkg::LVL0);
		run <= 1'b1;
		wait_svc(nic_pkg::VEC_MASK0, 8'h00, 1'b1);
		run <= 1'b0;
		rdc(nic_pkg::OFS_PEND, 32'h0);
		$display("external edge done");
	endtask : t_edge
	initial begin
		repeat (5) @(posedge hclk);
		hresetn <= 1'b1;
		t_reset();
		t_regs();
		t_arb();
		t_trap();
		t_edge();
		end_sim();
	end
endmodule : nic_ctrl_tb_top
`default_nettype wire
